// [design/vic_regs.vh]
// Register map, field positions, vectors and reset values of the interrupt controller
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

`define VIC_ADDR_W        8
`define VIC_NSRC          15

`define VIC_OFS_PRI_EN    8'hA8
`define VIC_OFS_EXT_EN    8'hE8
`define VIC_OFS_PRI_PRIO  8'hB8
`define VIC_OFS_EXT_PRIO  8'hF8
`define VIC_OFS_FLAGS     8'hC0
`define VIC_OFS_PIN_FLAGS 8'hC4
`define VIC_OFS_PIN_EN    8'hC8
`define VIC_OFS_PIN_EDGE  8'hCC
`define VIC_OFS_STATUS    8'hD0

`define VIC_RST_BYTE      8'h00
`define VIC_RST_PIN       16'h0000
`define VIC_RST_WORD      32'h0000_0000

`define VIC_GATE_BIT      7
`define VIC_IDX_TF0       1
`define VIC_IDX_TF1       3
`define VIC_IDX_I2CM      7
`define VIC_FLG_BKP       15
`define VIC_FLG_DBG       16

`define VIC_PIN0_W        4
`define VIC_PIN1_W        6
`define VIC_PIN1_LSB      8

`define VIC_VEC_BASE      8'h03
`define VIC_VEC_BKP       8'h7B
`define VIC_VEC_DBG       8'h83

`define VIC_LVL_LOW       2'b00
`define VIC_LVL_HIGH      2'b01
`define VIC_LVL_TOP       2'b10

`endif

// [design/vic_pin_edge.v]
// Pin synchroniser with agreement filter and selectable edge detection
module vic_pin_edge #(
   parameter W = 4
) (
   input  wire         clk,
   input  wire         rstn,
   input  wire [W-1:0] pinIn,
   input  wire [W-1:0] riseSel,
   output wire [W-1:0] edgeHit
);

   reg [W-1:0] sync1_q;
   reg [W-1:0] sync2_q;
   reg [W-1:0] sync3_q;
   reg [W-1:0] level_q;
   reg [W-1:0] level_d;

   genvar g;

   ////////////////////////////////////////////////////////////////////////////////
   // Filter: a change counts once stages two and three agree
   // One process for the whole vector keeps a single driver on level_d
   always @*
   begin
      level_d = ((sync2_q ~^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & level_q);
   end

   generate
      for (g = 0; g < W; g = g + 1)
      begin : gFilt
         assign edgeHit[g] = riseSel[g] ? (level_d[g] & ~level_q[g])
                                        : (~level_d[g] & level_q[g]);
      end
   endgenerate

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_q <= {W{1'b0}};
         sync2_q <= {W{1'b0}};
         sync3_q <= {W{1'b0}};
         level_q <= {W{1'b0}};
      end
      else
      begin
         sync1_q <= pinIn;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         level_q <= level_d;
      end
   end

endmodule // vic_pin_edge

// [design/vic_controller.v]
// Prioritised vectored interrupt controller with Avalon-MM register slave
//
// Our own choice: the Avalon-MM interface to the registers.
`include "vic_regs.vh"

module vic_controller (
   input  wire                    core_clk,
   input  wire                    rstn,
   input  wire [`VIC_ADDR_W-1:0]  avs_address,
   input  wire                    avs_read,
   input  wire                    avs_write,
   input  wire [31:0]             avs_writedata,
   input  wire [3:0]              avs_byteenable,
   output reg  [31:0]             avs_readdata,
   output reg                     avs_waitrequest,
   input  wire                    timer0Ovf,
   input  wire                    timer1Ovf,
   input  wire                    i2cMasterEvt,
   input  wire                    uart0Req,
   input  wire                    timer2Req,
   input  wire                    uart2Req,
   input  wire                    lowVoltReq,
   input  wire                    comparatorReq,
   input  wire                    adcPwmReq,
   input  wire                    watchdogReq,
   input  wire                    pcaReq,
   input  wire                    spiSlaveCecReq,
   input  wire                    rtcTimer3Req,
   input  wire [`VIC_PIN0_W-1:0]  pinGrp0In,
   input  wire [`VIC_PIN1_W-1:0]  pinGrp1In,
   input  wire                    debugPortMode,
   input  wire                    debugIdMatch,
   input  wire                    breakpointMatch,
   input  wire                    cpuTake,
   input  wire                    cpuReti,
   output reg                     irqValid_q,
   output reg  [7:0]              irqVector_q,
   output reg  [1:0]              irqLevel_q,
   output reg  [`VIC_NSRC-1:0]    srcAck_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   reg                    rstSync1_q;
   reg                    rstSync2_q;
   wire                   rstnInt;

   reg  [7:0]             priEn_q;
   reg  [7:0]             extEn_q;
   reg  [7:0]             priPrio_q;
   reg  [7:0]             extPrio_q;
   reg  [15:0]            pinEn_q;
   reg  [15:0]            pinEdge_q;
   reg  [15:0]            pinFlag_q;
   reg  [15:0]            pinFlag_d;
   reg                    tf0_q;
   reg                    tf1_q;
   reg                    i2cm_q;
   reg                    dbg_q;
   reg                    bkp_q;
   reg  [2:0]             inSvc_q;
   reg  [3:0]             winIdx_q;

   reg  [31:0]            rdData;
   reg                    nxtValid;
   reg  [7:0]             nxtVector;
   reg  [1:0]             nxtLevel;
   reg  [3:0]             nxtIdx;

   wire                   wrEn;
   wire                   wrLane0;
   wire [`VIC_PIN0_W-1:0] pin0Edge;
   wire [`VIC_PIN1_W-1:0] pin1Edge;
   wire [15:0]            pinEdgeAll;
   wire [15:0]            pinClr;
   wire                   pin0Flag;
   wire                   pin1Flag;
   wire [`VIC_NSRC-1:0]   srcFlag;
   wire [`VIC_NSRC-1:0]   enVec;
   wire [`VIC_NSRC-1:0]   prioVec;
   wire [`VIC_NSRC-1:0]   pend;
   wire [4:0]             hiPick;
   wire [4:0]             loPick;
   wire [31:0]            flagWord;
   wire [16:0]            flagClr;
   wire                   takeNow;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions
   // Lowest index wins: natural order puts index 0 first
   function [4:0] vic_first;
      input [`VIC_NSRC-1:0] v;
      integer i;
      begin
         vic_first = 5'h00;
         for (i = `VIC_NSRC - 1; i >= 0; i = i - 1)
         begin
            if (v[i])
               vic_first = {1'b1, i[3:0]};
         end
      end
   endfunction

   function regHit;
      input [`VIC_ADDR_W-1:0] a;
      input [`VIC_ADDR_W-1:0] ofs;
      begin
         regHit = (a == ofs);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end
      else
      begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end

   assign rstnInt = rstSync2_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin groups
   vic_pin_edge #(
      .W       (`VIC_PIN0_W)
   ) uPin0 (
      .clk     (core_clk),
      .rstn    (rstnInt),
      .pinIn   (pinGrp0In),
      .riseSel (pinEdge_q[`VIC_PIN0_W-1:0]),
      .edgeHit (pin0Edge)
   );

   vic_pin_edge #(
      .W       (`VIC_PIN1_W)
   ) uPin1 (
      .clk     (core_clk),
      .rstn    (rstnInt),
      .pinIn   (pinGrp1In),
      .riseSel (pinEdge_q[`VIC_PIN1_LSB+`VIC_PIN1_W-1:`VIC_PIN1_LSB]),
      .edgeHit (pin1Edge)
   );

   assign pinEdgeAll = {2'b00, pin1Edge, 4'h0, pin0Edge};

   // Latch only enabled pins; a new edge beats a same-cycle clear
   always @*
   begin
      pinFlag_d = (pinEdgeAll & pinEn_q) | (pinFlag_q & ~pinClr);
   end

   assign pin0Flag = |pinFlag_q[`VIC_PIN0_W-1:0];
   assign pin1Flag = |pinFlag_q[`VIC_PIN1_LSB+`VIC_PIN1_W-1:`VIC_PIN1_LSB];

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, then a single-cycle answer
   assign wrEn    = avs_write & ~avs_waitrequest;
   assign wrLane0 = wrEn & avs_byteenable[0];
   assign pinClr  = (wrEn && regHit(avs_address, `VIC_OFS_PIN_FLAGS)) ?
                    (avs_writedata[15:0] & {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}})
                    : `VIC_RST_PIN;
   assign flagClr = (wrEn && regHit(avs_address, `VIC_OFS_FLAGS)) ?
                    (avs_writedata[16:0] & {avs_byteenable[2], {8{avs_byteenable[1]}},
                                            {8{avs_byteenable[0]}}}) : 17'h0_0000;

   always @*
   begin
      rdData = `VIC_RST_WORD;
      case (avs_address)
         `VIC_OFS_PRI_EN:    rdData[7:0]  = priEn_q;
         `VIC_OFS_EXT_EN:    rdData[7:0]  = extEn_q;
         `VIC_OFS_PRI_PRIO:  rdData[6:0]  = priPrio_q[6:0];
         `VIC_OFS_EXT_PRIO:  rdData[7:0]  = extPrio_q;
         `VIC_OFS_FLAGS:     rdData       = flagWord;
         `VIC_OFS_PIN_FLAGS: rdData[15:0] = pinFlag_q;
         `VIC_OFS_PIN_EN:    rdData[15:0] = pinEn_q;
         `VIC_OFS_PIN_EDGE:  rdData[15:0] = pinEdge_q;
         `VIC_OFS_STATUS:    rdData[15:0] = {irqVector_q, irqLevel_q, irqValid_q,
                                             2'b00, inSvc_q};
         default:            rdData       = `VIC_RST_WORD;
      endcase
   end

   always @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= `VIC_RST_WORD;
      end
      else
      begin
         if ((avs_read | avs_write) & avs_waitrequest)
         begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rdData;
         end
         else
         begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   // Control registers; pin lanes honour their byte enables
   always @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         priEn_q   <= `VIC_RST_BYTE;
         extEn_q   <= `VIC_RST_BYTE;
         priPrio_q <= `VIC_RST_BYTE;
         extPrio_q <= `VIC_RST_BYTE;
         pinEn_q   <= `VIC_RST_PIN;
         pinEdge_q <= `VIC_RST_PIN;
         pinFlag_q <= `VIC_RST_PIN;
      end
      else
      begin
         pinFlag_q <= pinFlag_d;
         if (wrLane0 && regHit(avs_address, `VIC_OFS_PRI_EN))
            priEn_q <= avs_writedata[7:0];
         if (wrLane0 && regHit(avs_address, `VIC_OFS_EXT_EN))
            extEn_q <= avs_writedata[7:0];
         if (wrLane0 && regHit(avs_address, `VIC_OFS_PRI_PRIO))
            priPrio_q <= {1'b0, avs_writedata[6:0]};
         if (wrLane0 && regHit(avs_address, `VIC_OFS_EXT_PRIO))
            extPrio_q <= avs_writedata[7:0];
         if (wrEn && regHit(avs_address, `VIC_OFS_PIN_EN))
         begin
            if (avs_byteenable[0])
               pinEn_q[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
               pinEn_q[15:8] <= avs_writedata[15:8];
         end
         if (wrEn && regHit(avs_address, `VIC_OFS_PIN_EDGE))
         begin
            if (avs_byteenable[0])
               pinEdge_q[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
               pinEdge_q[15:8] <= avs_writedata[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Source flags
   // Mirrored lines follow their peripheral and have no writable state
   assign srcFlag = {rtcTimer3Req, spiSlaveCecReq, pcaReq, watchdogReq, adcPwmReq,
                     comparatorReq, lowVoltReq, i2cm_q, uart2Req, timer2Req,
                     uart0Req, tf1_q, pin1Flag, tf0_q, pin0Flag};
   assign flagWord = {15'h0000, dbg_q, bkp_q, srcFlag};

   assign takeNow = cpuTake & irqValid_q;

   // Writes only clear; an event in the clear cycle survives
   always @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         tf0_q  <= 1'b0;
         tf1_q  <= 1'b0;
         i2cm_q <= 1'b0;
         dbg_q  <= 1'b0;
         bkp_q  <= 1'b0;
      end
      else
      begin
         tf0_q  <= timer0Ovf | (tf0_q & ~flagClr[`VIC_IDX_TF0] &
                   ~(takeNow && nxtLvlIsPeriph(irqLevel_q) && winIdx_q == `VIC_IDX_TF0));
         tf1_q  <= timer1Ovf | (tf1_q & ~flagClr[`VIC_IDX_TF1] &
                   ~(takeNow && nxtLvlIsPeriph(irqLevel_q) && winIdx_q == `VIC_IDX_TF1));
         i2cm_q <= i2cMasterEvt | (i2cm_q & ~flagClr[`VIC_IDX_I2CM]);
         dbg_q  <= (debugPortMode & debugIdMatch) | (dbg_q & ~flagClr[`VIC_FLG_DBG]);
         bkp_q  <= breakpointMatch | (bkp_q & ~flagClr[`VIC_FLG_BKP]);
      end
   end

   function nxtLvlIsPeriph;
      input [1:0] lvl;
      begin
         nxtLvlIsPeriph = (lvl != `VIC_LVL_TOP);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Arbitration
   assign enVec   = {extEn_q, priEn_q[6:0]};
   assign prioVec = {extPrio_q, priPrio_q[6:0]};
   assign pend    = srcFlag & enVec & {`VIC_NSRC{priEn_q[`VIC_GATE_BIT]}};
   assign hiPick  = vic_first(pend & prioVec);
   assign loPick  = vic_first(pend);

   // Top level runs regardless of the global gate so a debugger can always stop the core
   always @*
   begin
      nxtValid  = 1'b0;
      nxtVector = `VIC_VEC_DBG;
      nxtLevel  = `VIC_LVL_TOP;
      nxtIdx    = 4'h0;
      if (dbg_q && !inSvc_q[2])
      begin
         nxtValid  = 1'b1;
         nxtVector = `VIC_VEC_DBG;
      end
      else if (bkp_q && !inSvc_q[2])
      begin
         nxtValid  = 1'b1;
         nxtVector = `VIC_VEC_BKP;
      end
      else if (hiPick[4] && inSvc_q[2:1] == 2'b00)
      begin
         nxtValid  = 1'b1;
         nxtLevel  = `VIC_LVL_HIGH;
         nxtIdx    = hiPick[3:0];
         nxtVector = `VIC_VEC_BASE + {1'b0, hiPick[3:0], 3'b000};
      end
      else if (loPick[4] && inSvc_q == 3'b000)
      begin
         nxtValid  = 1'b1;
         nxtLevel  = `VIC_LVL_LOW;
         nxtIdx    = loPick[3:0];
         nxtVector = `VIC_VEC_BASE + {1'b0, loPick[3:0], 3'b000};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // CPU side
   // Valid drops for one cycle after a take so stale state is never offered twice
   always @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         irqValid_q  <= 1'b0;
         irqVector_q <= `VIC_RST_BYTE;
         irqLevel_q  <= `VIC_LVL_LOW;
         winIdx_q    <= 4'h0;
         srcAck_q    <= {`VIC_NSRC{1'b0}};
         inSvc_q     <= 3'b000;
      end
      else
      begin
         srcAck_q <= {`VIC_NSRC{1'b0}};
         if (takeNow)
         begin
            irqValid_q <= 1'b0;
            inSvc_q    <= inSvc_q | (3'b001 << irqLevel_q);
            if (irqLevel_q != `VIC_LVL_TOP)
               srcAck_q <= {{(`VIC_NSRC-1){1'b0}}, 1'b1} << winIdx_q;
         end
         else
         begin
            irqValid_q  <= nxtValid;
            irqVector_q <= nxtVector;
            irqLevel_q  <= nxtLevel;
            winIdx_q    <= nxtIdx;
            if (cpuReti)
            begin
               if (inSvc_q[2])
                  inSvc_q[2] <= 1'b0;
               else if (inSvc_q[1])
                  inSvc_q[1] <= 1'b0;
               else
                  inSvc_q[0] <= 1'b0;
            end
         end
      end
   end

endmodule // vic_controller

// [dv/vic_chk.sv]
// Port assertions for the interrupt controller, bound to its top module
`include "vic_regs.vh"
module vic_chk (
   input logic                 core_clk,
   input logic                 rstn,
   input logic                 avs_read,
   input logic                 avs_write,
   input logic [31:0]          avs_readdata,
   input logic                 avs_waitrequest,
   input logic                 cpuTake,
   input logic                 irqValid_q,
   input logic [7:0]           irqVector_q,
   input logic [1:0]           irqLevel_q,
   input logic [`VIC_NSRC-1:0] srcAck_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_take;
      cpuTake && irqValid_q;
   endsequence
   sequence s_periph_take;
      s_take ##0 (irqLevel_q != `VIC_LVL_TOP);
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered next cycle");
   a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer lasted more than one cycle");
   a_answer_cause: assert property (!avs_waitrequest |-> $past((avs_read || avs_write) && avs_waitrequest))
      else $error("answer without a request");
   a_rdata_holds: assert property (!$fell(avs_waitrequest) |-> $stable(avs_readdata))
      else $error("read data moved outside an answer");
   a_take_drops: assert property (s_take |=> !irqValid_q)
      else $error("vector still offered after take");
   a_ack_vector: assert property (s_periph_take |=>
      srcAck_q == (15'h0001 << (($past(irqVector_q) - `VIC_VEC_BASE) >> 3)))
      else $error("acknowledge does not match taken vector");
   a_top_noack: assert property (s_take ##0 (irqLevel_q == `VIC_LVL_TOP) |=> srcAck_q == 15'h0000)
      else $error("acknowledge for a debug or breakpoint take");
   a_ack_cause: assert property (srcAck_q != 15'h0000 |-> $past(cpuTake && irqValid_q))
      else $error("acknowledge without take");
   a_ack_pulse: assert property (srcAck_q != 15'h0000 |=> srcAck_q == 15'h0000)
      else $error("acknowledge longer than one cycle");
   a_vec_grid: assert property (irqValid_q && irqLevel_q != `VIC_LVL_TOP
      |-> irqVector_q[2:0] == 3'h3 && irqVector_q <= 8'h73)
      else $error("peripheral vector off the grid");
   a_top_vec: assert property (irqValid_q && irqLevel_q == `VIC_LVL_TOP
      |-> irqVector_q == `VIC_VEC_DBG || irqVector_q == `VIC_VEC_BKP)
      else $error("top level with a peripheral vector");
endmodule // vic_chk

bind vic_controller vic_chk u_chk (
   .core_clk(core_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpuTake(cpuTake),
   .irqValid_q(irqValid_q), .irqVector_q(irqVector_q), .irqLevel_q(irqLevel_q),
   .srcAck_q(srcAck_q));

// [dv/vic_cpu_model.sv]
// Behavioural CPU: takes offered vectors, ends routines on request
module vic_cpu_model (
   input  logic       core_clk,
   input  logic       rstn,
   input  logic       irqValid_q,
   input  logic [7:0] irqVector_q,
   input  logic       slow,
   input  logic       retiReq,
   output logic       cpuTake,
   output logic       cpuReti,
   output logic [7:0] lastVec,
   output logic [7:0] takeCnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] waitCnt;
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cpuTake <= 1'b0;
         cpuReti <= 1'b0;
         lastVec <= 8'h00;
         takeCnt <= 8'h00;
         waitCnt <= 2'h0;
      end
      else
      begin
         cpuReti <= retiReq;
         cpuTake <= 1'b0;
         if (irqValid_q && !cpuTake)
         begin
            waitCnt <= waitCnt + 2'h1;
            // Slow core lets the offer stand a few cycles first
            if (!slow || waitCnt == 2'h3)
            begin
               cpuTake <= 1'b1;
               lastVec <= irqVector_q;
               takeCnt <= takeCnt + 8'h01;
               waitCnt <= 2'h0;
            end
         end
      end
   end
endmodule // vic_cpu_model

// [dv/vic_tb.sv]
// Self-checking bench: registers, flags, arbitration, vectors and nesting
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk      = 1'b0;
   logic        rstn          = 1'b0;
   logic [7:0]  avs_address   = 8'h00;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [14:0] ev            = 15'h0000;
   logic [3:0]  pin0          = 4'h0;
   logic [5:0]  pin1          = 6'h00;
   logic        dbgMode       = 1'b0;
   logic        dbgHit        = 1'b0;
   logic        bkpHit        = 1'b0;
   logic        slow          = 1'b0;
   logic        retiReq       = 1'b0;
   logic        cpuTake;
   logic        cpuReti;
   logic        irqValid_q;
   logic [7:0]  irqVector_q;
   logic [1:0]  irqLevel_q;
   logic [14:0] srcAck_q;
   logic [7:0]  lastVec;
   logic [7:0]  takeCnt;
   int          fail_count    = 0;
   int          checks_done   = 0;
   always #4 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////
   vic_controller u_dut (
      .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .timer0Ovf(ev[1]), .timer1Ovf(ev[3]), .i2cMasterEvt(ev[7]), .uart0Req(ev[4]),
      .timer2Req(ev[5]), .uart2Req(ev[6]), .lowVoltReq(ev[8]), .comparatorReq(ev[9]),
      .adcPwmReq(ev[10]), .watchdogReq(ev[11]), .pcaReq(ev[12]), .spiSlaveCecReq(ev[13]),
      .rtcTimer3Req(ev[14]), .pinGrp0In(pin0), .pinGrp1In(pin1), .debugPortMode(dbgMode),
      .debugIdMatch(dbgHit), .breakpointMatch(bkpHit), .cpuTake(cpuTake), .cpuReti(cpuReti),
      .irqValid_q(irqValid_q), .irqVector_q(irqVector_q), .irqLevel_q(irqLevel_q),
      .srcAck_q(srcAck_q));
   vic_cpu_model u_cpu (
      .core_clk(core_clk), .rstn(rstn), .irqValid_q(irqValid_q), .irqVector_q(irqVector_q),
      .slow(slow), .retiReq(retiReq), .cpuTake(cpuTake), .cpuReti(cpuReti),
      .lastVec(lastVec), .takeCnt(takeCnt));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Held until waitrequest is seen low; the watchdog ends a hang
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge core_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(q, exp);
   endtask
   task automatic rd_bits(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(q & m, exp);
   endtask
   task automatic expect_take(input logic [7:0] vec);
      logic [7:0] c0;
      c0 = takeCnt;
      repeat (40) if (takeCnt == c0) @(posedge core_clk);
      check({takeCnt - c0, lastVec}, {8'h01, vec});
   endtask
   task automatic no_take(input int n);
      logic [7:0] c0;
      c0 = takeCnt;
      repeat (n) @(posedge core_clk);
      check(takeCnt, c0);
   endtask
   task automatic reti();
      @(posedge core_clk);
      retiReq <= 1'b1;
      @(posedge core_clk);
      retiReq <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic clear_src(input int i);
      if (i == 0 || i == 2)
         wr(8'hC4, 32'h0000_0001 << (4 * i));
      else if (i == 7)
         wr(8'hC0, 32'h0000_0080);
      else
         ev[i] <= 1'b0;
   endtask
   task automatic finish_test();
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(8'hA8, 32'h0000_0000);
      rd(8'hE8, 32'h0000_0000);
      rd(8'hF8, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      wr(8'hB8, 32'h0000_00FF);
      rd(8'hB8, 32'h0000_007F);
      wr(8'hB8, 32'h0000_0000);
      wr(8'hE8, 32'h0000_00FE);
      rd(8'hE8, 32'h0000_00FE);
      wr(8'hA8, 32'h0000_007F);
      rd(8'hA8, 32'h0000_007F);
      wr(8'hC0, 32'h0001_FFFF);
      rd(8'hC0, 32'h0000_0000);
      // Gate off: pending flags must wait
      ev[4] <= 1'b1;
      no_take(10);
      wr(8'hC0, 32'h0000_0010);
      rd(8'hC0, 32'h0000_0010);
      wr(8'hC8, 32'h0000_0101);
      wr(8'hCC, 32'h0000_0001);
      pin0 <= 4'h1;
      pin1 <= 6'h01;
      repeat (10) @(posedge core_clk);
      rd(8'hC4, 32'h0000_0001);
      wr(8'hC0, 32'h0000_0001);
      rd(8'hC0, 32'h0000_0011);
      dbgHit <= 1'b1;
      @(posedge core_clk);
      dbgHit <= 1'b0;
      no_take(8);
      dbgMode <= 1'b1;
      dbgHit <= 1'b1;
      bkpHit <= 1'b1;
      @(posedge core_clk);
      dbgHit <= 1'b0;
      bkpHit <= 1'b0;
      expect_take(8'h83);
      wr(8'hC0, 32'h0001_0000);
      reti();
      expect_take(8'h7B);
      wr(8'hC0, 32'h0000_8000);
      reti();
      // Sweep all sources at one level; I2C master masked
      @(posedge core_clk);
      ev <= 15'h7FFA;
      pin1 <= 6'h00;
      @(posedge core_clk);
      ev <= 15'h7F70;
      wr(8'hA8, 32'h0000_00FF);
      for (int i = 0; i < 15; i++)
      begin
         if (i != 7)
         begin
            expect_take(8'(3 + 8 * i));
            clear_src(i);
            reti();
         end
      end
      rd(8'hC0, 32'h0000_0080);
      wr(8'hE8, 32'h0000_00FF);
      expect_take(8'h3B);
      clear_src(7);
      reti();
      // Level beats natural order, then nesting
      slow <= 1'b1;
      wr(8'hA8, 32'h0000_007F);
      wr(8'hF8, 32'h0000_0080);
      ev[4] <= 1'b1;
      ev[14] <= 1'b1;
      wr(8'hA8, 32'h0000_00FF);
      expect_take(8'h73);
      ev[14] <= 1'b0;
      reti();
      expect_take(8'h23);
      ev[12] <= 1'b1;
      no_take(10);
      wr(8'hF8, 32'h0000_0020);
      expect_take(8'h63);
      rd_bits(8'hD0, 32'h0000_0007, 32'h0000_0003);
      ev[12] <= 1'b0;
      reti();
      ev[4] <= 1'b0;
      reti();
      rd(8'hC0, 32'h0000_0000);
      rd_bits(8'hD0, 32'h0000_0027, 32'h0000_0000);
      finish_test();
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      finish_test();
   end
endmodule // tb
